// >>> src/dvp_app_end.sv
`timescale 1ns/100ps
`default_nettype none
`include "dvp_cfg.svh"

module dvp_app_end #(
  parameter int HALF_CYC = `DVP_HALF_DEFAULT_CYC
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire dvp_pkg::dvp_sample_t app_sample_i,
  output logic app_take_o,
  output var dvp_pkg::dvp_sample_t app_sample_o,
  output logic app_valid_o,
  dvp_link_if.app link
);
  import dvp_pkg::*;

  localparam int SW = `DVP_SAMPLE_W;
  localparam dvp_count_t CNT_FULL = dvp_count_t'(SW);
  localparam dvp_count_t CNT_ONE = dvp_count_t'(1);
  localparam dvp_div_t DIV_END = dvp_div_t'(HALF_CYC - 1);
  localparam dvp_div_t DIV_ONE = dvp_div_t'(1);

  // Band kept at elaboration; frame of 17 periods must fit the incoming deadline
  if (HALF_CYC < `DVP_HALF_MIN_CYC || HALF_CYC > `DVP_HALF_MAX_CYC) begin
    $error("HALF_CYC outside bit clock band");
  end
  if (2 * HALF_CYC * (SW + 1) * `DVP_SYS_PERIOD_NS > `DVP_RX_DONE_NS) begin
    $error("HALF_CYC too slow for incoming deadline");
  end

  // ****************************************************************
  // Bit clock divider, free running from reset release
  // ****************************************************************
  dvp_div_t div_q;
  dvp_div_t next_div;
  logic bclk_q;
  logic next_bclk;
  logic half_end;
  logic bclk_rise;
  logic bclk_fall;
  // Bit 1 outgoing frame, bit 0 outgoing data
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] sync3;
  logic [1:0] pin_lvl;
  logic [1:0] next_pin_lvl;

  always_comb begin
    half_end = (div_q == DIV_END);
    next_div = half_end ? '0 : div_q + DIV_ONE;
    // Not gated by the transfer state, so trail cycles exist whenever ce_i is high; lead cycles only until a tick is pending
    next_bclk = half_end ? ~bclk_q : bclk_q;
    bclk_rise = half_end & ~bclk_q;
    bclk_fall = half_end & bclk_q;
    for (int i = 0; i < 2; i++) begin
      next_pin_lvl[i] = dvp_agree(sync2[i], sync3[i], pin_lvl[i]);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      div_q <= '0;
      bclk_q <= 1'b0;
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      sync3 <= 2'h0;
      pin_lvl <= 2'h0;
    end else if (ce_i) begin
      div_q <= next_div;
      bclk_q <= next_bclk;
      sync1 <= {link.outgoing_frame_pulse, link.outgoing_sample_line};
      sync2 <= sync1;
      sync3 <= sync2;
      pin_lvl <= next_pin_lvl;
    end
  end

  assign link.serial_bit_clock_alt = bclk_q;

  // ****************************************************************
  // Receive from device and answer in the same frame
  // ****************************************************************
  dvp_count_t rx_cnt;
  dvp_count_t next_rx_cnt;
  dvp_sample_t rx_sh;
  dvp_sample_t next_rx_sh;
  dvp_sample_t next_app_sample;
  logic next_app_valid;
  logic arm;
  logic next_arm;
  dvp_shift_state_e tx_state;
  dvp_shift_state_e next_tx_state;
  dvp_sample_t tx_sh;
  dvp_sample_t next_tx_sh;
  dvp_count_t tx_cnt;
  dvp_count_t next_tx_cnt;
  logic frame_q;
  logic next_frame_q;
  logic data_q;
  logic next_data_q;
  logic next_take;

  always_comb begin
    next_rx_cnt = rx_cnt;
    next_rx_sh = rx_sh;
    next_app_sample = app_sample_o;
    next_app_valid = 1'b0;
    next_arm = arm;
    next_tx_state = tx_state;
    next_tx_sh = tx_sh;
    next_tx_cnt = tx_cnt;
    next_frame_q = frame_q;
    next_data_q = data_q;
    next_take = 1'b0;
    if (bclk_fall) begin
      if (next_pin_lvl[1]) begin
        // Each device frame paces one answer
        next_rx_cnt = CNT_FULL;
        next_arm = 1'b1;
      end else if (rx_cnt != '0) begin
        next_rx_sh = {rx_sh[SW-2:0], next_pin_lvl[0]};
        next_rx_cnt = rx_cnt - CNT_ONE;
        if (rx_cnt == CNT_ONE) begin
          next_app_sample = {rx_sh[SW-2:0], next_pin_lvl[0]};
          next_app_valid = 1'b1;
        end
      end
    end
    if (bclk_rise) begin
      if (arm) begin
        // Rises on the bit clock rise that ends the device frame
        next_frame_q = 1'b1;
        next_data_q = 1'b0;
        next_tx_sh = app_sample_i;
        next_tx_cnt = '0;
        next_take = 1'b1;
        next_arm = 1'b0;
        next_tx_state = SHF_FRAME;
      end else begin
        unique case (tx_state)
          SHF_IDLE: begin
            next_data_q = 1'b0;
          end
          SHF_FRAME: begin
            next_frame_q = 1'b0;
            next_data_q = tx_sh[SW-1];
            next_tx_sh = {tx_sh[SW-2:0], 1'b0};
            next_tx_cnt = CNT_ONE;
            next_tx_state = SHF_SHIFT;
          end
          SHF_SHIFT: begin
            if (tx_cnt == CNT_FULL) begin
              next_data_q = 1'b0;
              next_tx_state = SHF_IDLE;
            end else begin
              next_data_q = tx_sh[SW-1];
              next_tx_sh = {tx_sh[SW-2:0], 1'b0};
              next_tx_cnt = tx_cnt + CNT_ONE;
            end
          end
          default: begin
            next_frame_q = 1'b0;
            next_tx_state = SHF_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rx_cnt <= '0;
      rx_sh <= '0;
      app_sample_o <= '0;
      app_valid_o <= 1'b0;
      arm <= 1'b0;
      tx_state <= SHF_IDLE;
      tx_sh <= '0;
      tx_cnt <= '0;
      frame_q <= 1'b0;
      data_q <= 1'b0;
      app_take_o <= 1'b0;
    end else if (ce_i) begin
      rx_cnt <= next_rx_cnt;
      rx_sh <= next_rx_sh;
      app_sample_o <= next_app_sample;
      app_valid_o <= next_app_valid;
      arm <= next_arm;
      tx_state <= next_tx_state;
      tx_sh <= next_tx_sh;
      tx_cnt <= next_tx_cnt;
      frame_q <= next_frame_q;
      data_q <= next_data_q;
      app_take_o <= next_take;
    end
  end

  assign link.incoming_frame_pulse = frame_q;
  assign link.incoming_sample_line = data_q;

endmodule

`default_nettype wire

// >>> src/dvp_cfg.svh
// Overview of operation
// - Five lines: clock, outgoing pair, incoming pair
// - Port runs only from the external bit clock
// - Application makes bit clock, 0.2 to 10 MHz
// - Every transfer carries one 16-bit sample
// - Outgoing frame pulse: one period from rising edge
// - Sixteen following cycles shift outgoing sample out
// - New frame and sample about every 125 us
// - Incoming sample done within 100 us of frame
// - Incoming frame rises at outgoing frame fall or later; code raises it a few cycles before the device frame falls
// - Frames paced by network-locked 8 kHz tick
// - Frame spacing may wander one bit clock period
// - Application locks its rate to outgoing frames
// - Bit clock runs three cycles before first transfer; code starts a frame at the first bit clock rise with a tick pending
// - Bit clock runs three cycles after last bit
`ifndef DVP_CFG_SVH
`define DVP_CFG_SVH

`define DVP_SAMPLE_W 16
`define DVP_SYS_PERIOD_NS 5
// ****************************************************************
// Bit clock band and frame timing
// ****************************************************************
`define DVP_BCLK_PERIOD_MIN_NS 100
`define DVP_BCLK_PERIOD_MAX_NS 5000
`define DVP_RX_DONE_US 100
`define DVP_RX_DONE_NS (`DVP_RX_DONE_US * 1000)
// Least period rounds up, longest rounds down, in half periods
`define DVP_HALF_MIN_CYC \
  ((`DVP_BCLK_PERIOD_MIN_NS + 2 * `DVP_SYS_PERIOD_NS - 1) / (2 * `DVP_SYS_PERIOD_NS))
`define DVP_HALF_MAX_CYC (`DVP_BCLK_PERIOD_MAX_NS / (2 * `DVP_SYS_PERIOD_NS))
`define DVP_HALF_DEFAULT_CYC 13
`define DVP_SYNC_STAGES 3

`endif

// >>> src/dvp_pkg.sv
`include "dvp_cfg.svh"

package dvp_pkg;

  typedef logic [`DVP_SAMPLE_W-1:0] dvp_sample_t;
  typedef logic [$clog2(`DVP_SAMPLE_W+1)-1:0] dvp_count_t;
  typedef logic [$clog2(`DVP_HALF_MAX_CYC+1)-1:0] dvp_div_t;

  typedef enum logic [1:0] {
    SHF_IDLE = 2'b00,
    SHF_FRAME = 2'b01,
    SHF_SHIFT = 2'b10
  } dvp_shift_state_e;

  // Accept a pin change only once the two late stages agree
  function automatic logic dvp_agree(input logic s2, input logic s3, input logic cur);
    dvp_agree = (s2 == s3) ? s3 : cur;
  endfunction

endpackage

// >>> src/dvp_link_if.sv
`timescale 1ns/100ps
`default_nettype none

interface dvp_link_if;
  logic serial_bit_clock_alt;
  logic outgoing_sample_line;
  logic outgoing_frame_pulse;
  logic incoming_sample_line;
  logic incoming_frame_pulse;

  modport dev (
    input serial_bit_clock_alt,
    input incoming_sample_line,
    input incoming_frame_pulse,
    output outgoing_sample_line,
    output outgoing_frame_pulse
  );

  modport app (
    output serial_bit_clock_alt,
    output incoming_sample_line,
    output incoming_frame_pulse,
    input outgoing_sample_line,
    input outgoing_frame_pulse
  );
endinterface

`default_nettype wire

// >>> src/dvp_device_end.sv
`timescale 1ns/100ps
`default_nettype none
`include "dvp_cfg.svh"

module dvp_device_end (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic net_tick_i,
  input wire dvp_pkg::dvp_sample_t tx_sample_i,
  output logic tx_take_o,
  output var dvp_pkg::dvp_sample_t rx_sample_o,
  output logic rx_valid_o,
  dvp_link_if.dev link
);
  import dvp_pkg::*;

  localparam int SW = `DVP_SAMPLE_W;
  localparam dvp_count_t CNT_FULL = dvp_count_t'(SW);
  localparam dvp_count_t CNT_ONE = dvp_count_t'(1);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Bit 2 bit clock, bit 1 incoming frame, bit 0 incoming data
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_lvl;
  logic [2:0] next_sync1;
  logic [2:0] next_sync2;
  logic [2:0] next_sync3;
  logic [2:0] next_pin_lvl;
  logic bclk_rise;
  logic bclk_fall;

  always_comb begin
    next_sync1 = {link.serial_bit_clock_alt, link.incoming_frame_pulse,
                  link.incoming_sample_line};
    next_sync2 = sync1;
    next_sync3 = sync2;
    for (int i = 0; i < 3; i++) begin
      next_pin_lvl[i] = dvp_agree(sync2[i], sync3[i], pin_lvl[i]);
    end
    // Only the external clock paces the port
    bclk_rise = next_pin_lvl[2] & ~pin_lvl[2];
    bclk_fall = ~next_pin_lvl[2] & pin_lvl[2];
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
      pin_lvl <= 3'h0;
    end else if (ce_i) begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      sync3 <= next_sync3;
      pin_lvl <= next_pin_lvl;
    end
  end

  // ****************************************************************
  // Outgoing path
  // ****************************************************************
  dvp_shift_state_e tx_state;
  dvp_shift_state_e next_tx_state;
  dvp_sample_t tx_sh;
  dvp_sample_t next_tx_sh;
  dvp_count_t tx_cnt;
  dvp_count_t next_tx_cnt;
  logic tick_pend;
  logic next_tick_pend;
  logic frame_q;
  logic next_frame_q;
  logic data_q;
  logic next_data_q;
  logic next_take;
  logic tx_start;

  always_comb begin
    next_tx_state = tx_state;
    next_tx_sh = tx_sh;
    next_tx_cnt = tx_cnt;
    next_frame_q = frame_q;
    next_data_q = data_q;
    next_take = 1'b0;
    // Tick waits for the next bit clock rise, hence up to one period of wander
    next_tick_pend = tick_pend | net_tick_i;
    // A new frame may follow the last bit directly
    tx_start = bclk_rise & tick_pend &
               ((tx_state == SHF_IDLE) ||
                ((tx_state == SHF_SHIFT) && (tx_cnt == CNT_FULL)));
    if (tx_start) begin
      next_frame_q = 1'b1;
      next_data_q = 1'b0;
      next_tx_sh = tx_sample_i;
      next_tx_cnt = '0;
      next_take = 1'b1;
      next_tx_state = SHF_FRAME;
      // Set wins over the clear
      next_tick_pend = net_tick_i;
    end else if (bclk_rise) begin
      unique case (tx_state)
        SHF_IDLE: begin
          next_data_q = 1'b0;
        end
        SHF_FRAME: begin
          next_frame_q = 1'b0;
          next_data_q = tx_sh[SW-1];
          next_tx_sh = {tx_sh[SW-2:0], 1'b0};
          next_tx_cnt = CNT_ONE;
          next_tx_state = SHF_SHIFT;
        end
        SHF_SHIFT: begin
          if (tx_cnt == CNT_FULL) begin
            next_data_q = 1'b0;
            next_tx_state = SHF_IDLE;
          end else begin
            next_data_q = tx_sh[SW-1];
            next_tx_sh = {tx_sh[SW-2:0], 1'b0};
            next_tx_cnt = tx_cnt + CNT_ONE;
          end
        end
        default: begin
          next_frame_q = 1'b0;
          next_tx_state = SHF_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      tx_state <= SHF_IDLE;
      tx_sh <= '0;
      tx_cnt <= '0;
      tick_pend <= 1'b0;
      frame_q <= 1'b0;
      data_q <= 1'b0;
      tx_take_o <= 1'b0;
    end else if (ce_i) begin
      tx_state <= next_tx_state;
      tx_sh <= next_tx_sh;
      tx_cnt <= next_tx_cnt;
      tick_pend <= next_tick_pend;
      frame_q <= next_frame_q;
      data_q <= next_data_q;
      tx_take_o <= next_take;
    end
  end

  assign link.outgoing_frame_pulse = frame_q;
  assign link.outgoing_sample_line = data_q;

  // ****************************************************************
  // Incoming path
  // ****************************************************************
  dvp_sample_t rx_sh;
  dvp_sample_t next_rx_sh;
  dvp_count_t rx_cnt;
  dvp_count_t next_rx_cnt;
  dvp_sample_t next_rx_sample;
  logic next_rx_valid;

  always_comb begin
    next_rx_sh = rx_sh;
    next_rx_cnt = rx_cnt;
    next_rx_sample = rx_sample_o;
    next_rx_valid = 1'b0;
    if (bclk_fall) begin
      // Frame seen high on a fall arms the next 16 falls
      if (next_pin_lvl[1]) begin
        next_rx_cnt = CNT_FULL;
      end else if (rx_cnt != '0) begin
        next_rx_sh = {rx_sh[SW-2:0], next_pin_lvl[0]};
        next_rx_cnt = rx_cnt - CNT_ONE;
        if (rx_cnt == CNT_ONE) begin
          next_rx_sample = {rx_sh[SW-2:0], next_pin_lvl[0]};
          next_rx_valid = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rx_sh <= '0;
      rx_cnt <= '0;
      rx_sample_o <= '0;
      rx_valid_o <= 1'b0;
    end else if (ce_i) begin
      rx_sh <= next_rx_sh;
      rx_cnt <= next_rx_cnt;
      rx_sample_o <= next_rx_sample;
      rx_valid_o <= next_rx_valid;
    end
  end

endmodule

`default_nettype wire

// >>> sim/dvp_link_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "dvp_cfg.svh"

module dvp_link_properties #(
  parameter int HALF_CYC = `DVP_HALF_DEFAULT_CYC
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic serial_bit_clock_alt,
  input wire logic outgoing_sample_line,
  input wire logic outgoing_frame_pulse,
  input wire logic incoming_sample_line,
  input wire logic incoming_frame_pulse
);
  localparam int FRAME_CYC = 2 * HALF_CYC;
  localparam int MIN_GAP = 34 * HALF_CYC;
  logic bclk_q;
  logic frame_q;
  logic seen_edge;
  logic [15:0] run_cnt;
  logic [15:0] hi_cnt;
  logic [15:0] gap_cnt;
  logic [4:0] tx_cnt;

  // ********
  // Helpers
  // ********
  always_ff @(posedge clk_sys_i) begin
    bclk_q <= serial_bit_clock_alt;
    frame_q <= outgoing_frame_pulse;
    if (!nrst_i) begin
      seen_edge <= 1'b0;
      run_cnt <= 16'h0000;
      hi_cnt <= 16'h0000;
      gap_cnt <= 16'hFFFF;
      tx_cnt <= 5'h00;
    end else begin
      seen_edge <= seen_edge | (serial_bit_clock_alt != bclk_q);
      run_cnt <= (serial_bit_clock_alt != bclk_q) ? 16'h0001 : run_cnt + 16'h0001;
      hi_cnt <= outgoing_frame_pulse ? hi_cnt + 16'h0001 : 16'h0000;
      if (outgoing_frame_pulse && !frame_q) begin
        gap_cnt <= 16'h0001;
      end else if (gap_cnt != 16'hFFFF) begin
        gap_cnt <= gap_cnt + 16'h0001;
      end
      // Bit slots counted from raw rises; the device lags each rise a few cycles
      if (serial_bit_clock_alt && !bclk_q) begin
        if (outgoing_frame_pulse) begin
          tx_cnt <= 5'h01;
        end else if (tx_cnt == 5'h11) begin
          tx_cnt <= 5'h00;
        end else if (tx_cnt != 5'h00) begin
          tx_cnt <= tx_cnt + 5'h01;
        end
      end
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  // ***********
  // Properties
  // ***********
  // Only a lower bound: a frozen clock is legal
  property p_bclk_rate;
    (serial_bit_clock_alt != bclk_q) && seen_edge |-> run_cnt >= HALF_CYC;
  endproperty
  a_bclk_rate: assert property (p_bclk_rate) else $error("bit clock too fast");
  property p_frame_width;
    $fell(outgoing_frame_pulse) |-> hi_cnt == FRAME_CYC;
  endproperty
  a_frame_width: assert property (p_frame_width) else $error("frame width");
  property p_frame_on_rise;
    $rose(outgoing_frame_pulse) |-> serial_bit_clock_alt;
  endproperty
  a_frame_on_rise: assert property (p_frame_on_rise) else $error("frame edge");
  property p_tx_on_rise;
    $changed(outgoing_sample_line) |-> serial_bit_clock_alt;
  endproperty
  a_tx_on_rise: assert property (p_tx_on_rise) else $error("tx data edge");
  property p_rx_on_rise;
    $changed(incoming_sample_line) || $changed(incoming_frame_pulse) |-> serial_bit_clock_alt;
  endproperty
  a_rx_on_rise: assert property (p_rx_on_rise) else $error("rx line edge");
  property p_tx_quiet;
    outgoing_frame_pulse |-> !outgoing_sample_line;
  endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("data in frame slot");
  property p_tx_slots;
    outgoing_sample_line |-> tx_cnt != 5'h00;
  endproperty
  a_tx_slots: assert property (p_tx_slots) else $error("data past 16 bits");
  property p_rx_frame;
    $rose(incoming_frame_pulse) |-> ##[0:8] $fell(outgoing_frame_pulse);
  endproperty
  a_rx_frame: assert property (p_rx_frame) else $error("reply frame timing");
  property p_spacing;
    $rose(outgoing_frame_pulse) |-> gap_cnt >= MIN_GAP;
  endproperty
  a_spacing: assert property (p_spacing) else $error("frames too close");

  c_frame: cover property ($rose(outgoing_frame_pulse));
  c_reply: cover property ($rose(incoming_frame_pulse));
  c_b2b: cover property ($rose(outgoing_frame_pulse) && gap_cnt == MIN_GAP);
endmodule

`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import dvp_pkg::*;
  localparam int HALF = 10;
  localparam int GAP = 2000;
  logic clk_sys_i;
  logic nrst_i;
  logic dev_ce;
  logic app_ce;
  logic net_tick;
  dvp_sample_t tx_sample;
  dvp_sample_t app_sample;
  dvp_sample_t rx_sample;
  dvp_sample_t app_rx;
  logic tx_take;
  logic rx_valid;
  logic app_valid;
  logic app_take;
  logic frame_q = 1'b0;
  int err_total;
  int n_compared;
  int ev_cnt [5] = '{default: 0};
  int cyc = 0;
  int rise_cyc = 0;
  int last_gap = 0;

  dvp_link_if link ();
  dvp_device_end u_dvp_device_end (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(dev_ce),
    .net_tick_i(net_tick), .tx_sample_i(tx_sample), .tx_take_o(tx_take),
    .rx_sample_o(rx_sample), .rx_valid_o(rx_valid), .link(link));
  dvp_app_end #(.HALF_CYC(HALF)) u_dvp_app_end (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .ce_i(app_ce), .app_sample_i(app_sample), .app_take_o(app_take), .app_sample_o(app_rx),
    .app_valid_o(app_valid), .link(link));
  dvp_link_properties #(.HALF_CYC(HALF)) u_dvp_link_properties (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .serial_bit_clock_alt(link.serial_bit_clock_alt),
    .outgoing_sample_line(link.outgoing_sample_line),
    .outgoing_frame_pulse(link.outgoing_frame_pulse),
    .incoming_sample_line(link.incoming_sample_line),
    .incoming_frame_pulse(link.incoming_frame_pulse));

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // ****************
  // Event counters
  // ****************
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    frame_q <= link.outgoing_frame_pulse;
    if (link.outgoing_frame_pulse && !frame_q) begin
      last_gap <= cyc - rise_cyc;
      rise_cyc <= cyc;
      ev_cnt[0] <= ev_cnt[0] + 1;
    end
    if (tx_take) ev_cnt[1] <= ev_cnt[1] + 1;
    if (app_valid) ev_cnt[2] <= ev_cnt[2] + 1;
    if (rx_valid) ev_cnt[3] <= ev_cnt[3] + 1;
    if (app_take) ev_cnt[4] <= ev_cnt[4] + 1;
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_ev(input int idx, input int target, input int limit);
    int n;
    n = 0;
    while (ev_cnt[idx] < target && n < limit) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (ev_cnt[idx] < target) begin
      err_total++;
      $display("[FAIL] event %0d expected %0d seen %0d", idx, target, ev_cnt[idx]);
      test_done();
    end
  endtask

  task automatic tick();
    net_tick = 1'b1;
    @(negedge clk_sys_i);
    net_tick = 1'b0;
  endtask

  // One word each way, both checked at the far end
  task automatic xfer(input dvp_sample_t tx, input dvp_sample_t rx);
    int n1;
    int n2;
    int n3;
    int t0;
    n1 = ev_cnt[1] + 1;
    n2 = ev_cnt[2] + 1;
    n3 = ev_cnt[3] + 1;
    tx_sample = tx;
    app_sample = rx;
    tick();
    wait_ev(1, n1, 200);
    t0 = cyc;
    wait_ev(2, n2, 1000);
    check("app word", 32'(app_rx), 32'(tx));
    wait_ev(3, n3, 20000);
    check("dev word", 32'(rx_sample), 32'(rx));
    check("rx in time", 32'(cyc - t0 < 20000), 32'h0000_0001);
    // Bit clock keeps running well past the last bit
    repeat (GAP) @(negedge clk_sys_i);
  endtask

  task automatic test_words();
    dvp_sample_t w [5] = '{16'h8001, 16'h0001, 16'hA5C3, 16'hFFFF, 16'h0000};
    foreach (w[i]) xfer(w[i], ~w[i]);
    $display("test_words done");
  endtask

  task automatic test_pacing();
    int f0;
    int d;
    int a0;
    f0 = ev_cnt[0];
    a0 = ev_cnt[4];
    for (int i = 0; i < 4; i++) begin
      tick();
      repeat (GAP - 1) @(negedge clk_sys_i);
      d = last_gap - GAP;
      if (i > 0) check("gap", 32'(d <= 2 * HALF && d >= -2 * HALF), 32'h0000_0001);
    end
    check("frames per tick", 32'(ev_cnt[0] - f0), 32'h0000_0004);
    check("answers per frame", 32'(ev_cnt[4] - a0), 32'h0000_0004);
    $display("test_pacing done");
  endtask

  task automatic test_back_to_back();
    int f0;
    int v0;
    f0 = ev_cnt[0];
    v0 = ev_cnt[2];
    tick();
    wait_ev(0, f0 + 1, 100);
    repeat (3) begin
      repeat (50) @(negedge clk_sys_i);
      tick();
    end
    wait_ev(0, f0 + 2, 1000);
    check("b2b gap", 32'(last_gap), 32'(34 * HALF));
    repeat (GAP) @(negedge clk_sys_i);
    check("merged ticks", 32'(ev_cnt[0] - f0), 32'h0000_0002);
    check("b2b words", 32'(ev_cnt[2] - v0), 32'h0000_0002);
    $display("test_back_to_back done");
  endtask

  task automatic test_clock_gate();
    int f0;
    app_ce = 1'b0;
    f0 = ev_cnt[0];
    tick();
    repeat (400) @(negedge clk_sys_i);
    check("no frame without bit clock", 32'(ev_cnt[0] - f0), 32'h0000_0000);
    app_ce = 1'b1;
    wait_ev(0, f0 + 1, 100);
    repeat (GAP) @(negedge clk_sys_i);
    // Frozen device must not take a tick
    dev_ce = 1'b0;
    f0 = ev_cnt[0];
    tick();
    repeat (100) @(negedge clk_sys_i);
    dev_ce = 1'b1;
    repeat (400) @(negedge clk_sys_i);
    check("tick ignored while frozen", 32'(ev_cnt[0] - f0), 32'h0000_0000);
    $display("test_clock_gate done");
  endtask

  task automatic test_reset_mid();
    tick();
    repeat (150) @(negedge clk_sys_i);
    nrst_i = 1'b0;
    repeat (5) @(negedge clk_sys_i);
    check("lines idle", 32'({link.serial_bit_clock_alt, link.outgoing_sample_line,
      link.outgoing_frame_pulse, link.incoming_sample_line, link.incoming_frame_pulse}),
      32'h0000_0000);
    nrst_i = 1'b1;
    repeat (40) @(negedge clk_sys_i);
    xfer(16'h1234, 16'hCDEF);
    $display("test_reset_mid done");
  endtask

  initial begin
    nrst_i = 1'b0;
    dev_ce = 1'b1;
    app_ce = 1'b1;
    net_tick = 1'b0;
    tx_sample = 16'h0000;
    app_sample = 16'h0000;
    err_total = 0;
    n_compared = 0;
    repeat (5) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    // Bit clock runs two periods (40 cycles) before the first tick
    repeat (40) @(negedge clk_sys_i);
    test_words();
    test_pacing();
    test_back_to_back();
    test_clock_gate();
    test_reset_mid();
    test_done();
  end
endmodule

`default_nettype wire
